/* dv/clkpm_monitor.sv */
// Port-level assertions for the clock and power manager
`timescale 1ns/1ps
`default_nettype none

module clkpm_monitor #(
  parameter int unsigned DEGLITCH_CYCLES = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_usb_configured,
  input wire logic i_usb_reset,
  input wire logic i_usb_suspend,
  input wire logic i_usb_resume,
  input wire logic [2:0] i_video_connected,
  input wire logic o_xtal_en,
  input wire logic o_phy_en,
  input wire logic o_usb_device_core_en,
  input wire logic o_func_en,
  input wire logic [2:0] o_video_en,
  input wire logic [1:0] o_sys_pll_stage_reset,
  input wire logic [1:0] o_sys_pll_stage_bypass,
  input wire logic [1:0] o_pix_pll_stage_reset,
  input wire logic [1:0] o_pix_pll_stage_bypass,
  input wire logic [2:0] o_power_state
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Enables lag the registered state by one cycle
  chk_func_config: assert property (
    o_func_en == ($past(o_power_state) == 3'h3))
    else $error("function enable disagrees with state");
  chk_phy_power: assert property (
    o_phy_en == ($past(o_power_state) inside {3'h2, 3'h3, 3'h4}))
    else $error("phy enable disagrees with state");
  chk_core_phy: assert property (o_usb_device_core_en == o_phy_en)
    else $error("device core enable differs from phy enable");
  chk_xtal_run: assert property (
    $past(o_power_state) inside {3'h2, 3'h3} |-> o_xtal_en)
    else $error("oscillator off while running");
  chk_video_gate: assert property (
    o_video_en != 3'h0 |-> o_func_en &&
      ((o_video_en & ~$past(i_video_connected)) == 3'h0))
    else $error("video output without connection or config");
  chk_pll_held: assert property (
    !o_func_en |-> {o_sys_pll_stage_reset, o_sys_pll_stage_bypass,
      o_pix_pll_stage_reset, o_pix_pll_stage_bypass} == 8'hff)
    else $error("pll stages released outside configured");
  // State moves
  chk_suspend_hold: assert property (
    o_power_state == 3'h4 && !i_usb_resume && !i_usb_reset
      |=> o_power_state inside {3'h4, 3'h1})
    else $error("suspend left without resume");
  chk_config_step: assert property (
    o_power_state == 3'h2 && i_usb_configured && !i_usb_reset &&
      !i_usb_suspend |=> o_power_state inside {3'h3, 3'h1})
    else $error("configuration not taken");
  chk_usb_reset: assert property (
    o_power_state == 3'h3 && i_usb_reset
      |=> o_power_state inside {3'h2, 3'h1})
    else $error("bus reset did not leave configured");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : clkpm_monitor

bind clkpm_top clkpm_monitor #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES))
  clkpm_monitor_i (.i_clk, .i_rstn, .i_rd, .o_rdata, .i_usb_configured,
  .i_usb_reset, .i_usb_suspend, .i_usb_resume, .i_video_connected,
  .o_xtal_en, .o_phy_en, .o_usb_device_core_en, .o_func_en, .o_video_en,
  .o_sys_pll_stage_reset, .o_sys_pll_stage_bypass, .o_pix_pll_stage_reset,
  .o_pix_pll_stage_bypass, .o_power_state);

`default_nettype wire

/* dv/clkpm_pll_model.sv */
// Behavioural two-stage PLL macro: output clock and lock levels
`timescale 1ns/1ps
`default_nettype none

module clkpm_pll_model #(
  parameter int FEEDBACK_FIELD = 17,
  parameter int LOCK_NS = 20000
) (
  input wire logic [1:0] i_stage_reset,
  input wire logic [1:0] i_stage_bypass,
  output logic o_clk,
  output logic [1:0] o_locked
);
  // Field holds the divide plus one; 25 MHz reference times the divide
  localparam real HALF_NS = 20.0 / (FEEDBACK_FIELD - 1);

  // Output held low while a stage sits in reset
  initial begin
    o_clk = 1'b0;
    forever begin
      #HALF_NS;
      o_clk = (i_stage_reset == 2'h0) ? ~o_clk : 1'b0;
    end
  end
  // Lock indicators rise some time after normal mode is selected
  always @(i_stage_reset, i_stage_bypass) begin
    o_locked = 2'h0;
    if ({i_stage_reset, i_stage_bypass} == 4'h0) begin
      #LOCK_NS;
      if ({i_stage_reset, i_stage_bypass} == 4'h0) o_locked = 2'h3;
    end
  end
endmodule : clkpm_pll_model

`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the clock and power manager
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic i_clk, i_rstn, i_wr, i_rd, i_bus_voltage_detect;
  logic i_usb_configured, i_usb_reset, i_usb_suspend, i_usb_resume;
  logic [15:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [2:0] i_video_connected, o_video_en, o_power_state;
  logic [1:0] i_sys_pll_stage_locked, i_pix_pll_stage_locked;
  logic [1:0] o_sys_pll_stage_reset, o_sys_pll_stage_bypass;
  logic [1:0] o_pix_pll_stage_reset, o_pix_pll_stage_bypass;
  logic i_sys_pll_clk, i_pix_pll_clk, o_xtal_en, o_phy_en, o_func_en;
  logic o_usb_device_core_en, o_memory_clock, o_core_clock, o_pixel_clock;
  logic [17:0] outs;
  int bad_count = 0;
  int num_checks = 0;
  int src_n[2];
  int div_n[2];
  int core_n;
  int d;
  logic self_refresh_request = 1'b0;
  logic [2:0] memctl_state_field = 3'h0;

  clkpm_top #(.DEGLITCH_CYCLES(8)) clkpm_top_i (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_bus_voltage_detect(i_bus_voltage_detect),
    .i_usb_configured(i_usb_configured), .i_usb_reset(i_usb_reset),
    .i_usb_suspend(i_usb_suspend), .i_usb_resume(i_usb_resume),
    .i_video_connected(i_video_connected),
    .i_sys_pll_stage_locked(i_sys_pll_stage_locked),
    .i_pix_pll_stage_locked(i_pix_pll_stage_locked),
    .i_sys_pll_clk(i_sys_pll_clk), .i_pix_pll_clk(i_pix_pll_clk),
    .o_xtal_en(o_xtal_en), .o_phy_en(o_phy_en),
    .o_usb_device_core_en(o_usb_device_core_en), .o_func_en(o_func_en),
    .o_video_en(o_video_en),
    .o_sys_pll_stage_reset(o_sys_pll_stage_reset),
    .o_sys_pll_stage_bypass(o_sys_pll_stage_bypass),
    .o_pix_pll_stage_reset(o_pix_pll_stage_reset),
    .o_pix_pll_stage_bypass(o_pix_pll_stage_bypass),
    .o_memory_clock(o_memory_clock), .o_core_clock(o_core_clock),
    .o_pixel_clock(o_pixel_clock), .o_power_state(o_power_state));
  clkpm_pll_model #(.FEEDBACK_FIELD(17)) pll_sys_i (
    .i_stage_reset(o_sys_pll_stage_reset),
    .i_stage_bypass(o_sys_pll_stage_bypass),
    .o_clk(i_sys_pll_clk), .o_locked(i_sys_pll_stage_locked));
  clkpm_pll_model #(.FEEDBACK_FIELD(9)) pll_pix_i (
    .i_stage_reset(o_pix_pll_stage_reset),
    .i_stage_bypass(o_pix_pll_stage_bypass),
    .o_clk(i_pix_pll_clk), .o_locked(i_pix_pll_stage_locked));

  assign outs = {o_xtal_en, o_phy_en, o_usb_device_core_en, o_func_en,
    o_video_en, o_sys_pll_stage_reset, o_sys_pll_stage_bypass,
    o_pix_pll_stage_reset, o_pix_pll_stage_bypass, o_power_state};

  // Edge counters for the PLL and divided clocks
  always @(posedge i_sys_pll_clk) src_n[0]++;
  always @(posedge i_pix_pll_clk) src_n[1]++;
  always @(posedge o_memory_clock) div_n[0]++;
  always @(posedge o_pixel_clock) div_n[1]++;
  always @(posedge o_core_clock) core_n++;

  // Memory controller stand-in: reports self-refresh a cycle after request
  always @(posedge i_clk) begin
    memctl_state_field <= self_refresh_request ? 3'h3 : 3'h1;
  end

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic chk_outs(input logic [17:0] exp);
    chk("outputs", {14'h0, outs}, {14'h0, exp});
  endtask : chk_outs

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  // Mask bit 0 configured, 1 bus reset, 2 suspend, 3 resume
  task automatic pulse(input logic [3:0] m);
    @(posedge i_clk);
    {i_usb_resume, i_usb_suspend, i_usb_reset, i_usb_configured} <= m;
    @(posedge i_clk);
    {i_usb_resume, i_usb_suspend, i_usb_reset, i_usb_configured} <= 4'h0;
    cyc(3);
  endtask : pulse

  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(nm, v, exp);
  endtask : rd_chk

  // Software asks for self-refresh and polls the state field for 3h
  task automatic set_self_refresh(input logic on);
    @(posedge i_clk);
    self_refresh_request <= on;
    repeat (4) begin
      @(posedge i_clk);
      if ((memctl_state_field == 3'h3) == on) break;
    end
  endtask : set_self_refresh

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the expected run time
  initial begin
    repeat (25000) @(posedge i_clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    {i_wr, i_rd, i_usb_configured, i_usb_reset} = 4'h0;
    {i_usb_suspend, i_usb_resume, i_rstn} = 3'h0;
    i_addr = 16'h0;
    i_wdata = 32'h0;
    i_bus_voltage_detect = 1'b1;
    i_video_connected = 3'h5;
    cyc(4);
    i_rstn <= 1'b1;
    cyc(4);
    chk_outs({4'he, 3'h0, 8'hff, 3'h2});
    rd_chk("pix ctrl", 16'h7000, 32'h8000_000f);
    rd_chk("sys ctrl", 16'h700c, 32'h8000_000f);
    rd_chk("status", 16'h7024, 32'h0000_000a);
    rd_chk("unmapped", 16'h7018, 32'h0);
    $display("test reset done");
    wr(16'h7020, 32'h0000_0030);
    pulse(4'h1);
    chk_outs({4'hf, 3'h1, 8'hff, 3'h3});
    $display("test configure done");
    for (int p = 0; p < 2; p++) begin
      automatic logic [15:0] a = (p == 0) ? 16'h700c : 16'h7000;
      if (p == 0) set_self_refresh(1'b1);
      wr(a, 32'h8000_0000);
      #100000;
      rd_chk("lock status", a, 32'h8000_0030);
      div_n[p] = 0;
      #1000 chk("gated edges", div_n[p], 32'h0);
      wr(a, 32'h0);
      #200 src_n[p] = 0;
      div_n[p] = 0;
      core_n = 0;
      #2000 d = src_n[p] / 2 - div_n[p];
      chk("half", {31'h0, d >= -1 && d <= 1}, 32'h1);
      d = src_n[p] / 4 - core_n;
      if (p == 0) chk("core", {31'h0, d >= -1 && d <= 1}, 32'h1);
      wr(a, 32'h8000_000f);
      #200 div_n[p] = 0;
      #1000 chk("stopped edges", div_n[p], 32'h0);
      if (p == 0) set_self_refresh(1'b0);
    end
    $display("test pll done");
    set_self_refresh(1'b1);
    pulse(4'h4);
    chk_outs({4'h6, 3'h0, 8'hff, 3'h4});
    cyc(20);
    chk_outs({4'h6, 3'h0, 8'hff, 3'h4});
    pulse(4'h8);
    chk_outs({4'hf, 3'h1, 8'hff, 3'h3});
    wr(16'h7020, 32'h0000_0031);
    pulse(4'h4);
    chk_outs({4'he, 3'h0, 8'hff, 3'h4});
    pulse(4'h8);
    pulse(4'h2);
    chk_outs({4'he, 3'h0, 8'hff, 3'h2});
    set_self_refresh(1'b0);
    $display("test suspend done");
    wr(16'h7020, 32'h0000_0002);
    i_bus_voltage_detect <= 1'b0;
    cyc(3);
    i_bus_voltage_detect <= 1'b1;
    rd_chk("held status", 16'h7024, 32'h0000_0001);
    chk_outs({4'h0, 3'h0, 8'hff, 3'h1});
    cyc(14);
    rd_chk("late status", 16'h7024, 32'h0000_000a);
    chk_outs({4'he, 3'h0, 8'hff, 3'h2});
    $display("test deglitch done");
    i_rstn <= 1'b0;
    cyc(1);
    chk_outs({4'h0, 3'h0, 8'hff, 3'h0});
    cyc(4);
    chk_outs({4'h0, 3'h0, 8'hff, 3'h0});
    i_rstn <= 1'b1;
    cyc(4);
    chk_outs({4'he, 3'h0, 8'hff, 3'h2});
    $display("test reset pin done");
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire

/* logic/clkpm_clkdiv.sv */
// Integer clock divider with a glitch-free stop control
`timescale 1ns/1ps
`default_nettype none

module clkpm_clkdiv #(
  parameter int unsigned DIV = 2
) (
  input wire logic i_src_clk,
  input wire logic i_rstn,
  input wire logic i_gate,
  output logic o_clk
);

  localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2);

  // Refuse a ratio that cannot give an even duty cycle
  if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
    $error("DIV must be even and at least two");
  end

  logic gate_meta;
  logic gate_sync;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_clk;

  // Stop only at the end of a low phase so no short pulse escapes
  always_comb begin
    next_cnt = cnt;
    next_clk = o_clk;
    if (cnt == LAST) begin
      if (!gate_sync) begin
        next_cnt = '0;
        next_clk = 1'b1;
      end else begin
        next_clk = 1'b0;
      end
    end else begin
      next_cnt = cnt + 1'b1;
      next_clk = (cnt + 1'b1) < HALF;
    end
  end

  // Gate crosses into the PLL clock through two flip-flops
  always_ff @(posedge i_src_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gate_meta <= 1'b1;
      gate_sync <= 1'b1;
      cnt <= LAST;
      o_clk <= 1'b0;
    end else begin
      gate_meta <= i_gate;
      gate_sync <= gate_meta;
      cnt <= next_cnt;
      o_clk <= next_clk;
    end
  end

endmodule : clkpm_clkdiv

`default_nettype wire

/* logic/clkpm_deglitch.sv */
// Bus-voltage deglitcher with a hold-off timer
`timescale 1ns/1ps
`default_nettype none

module clkpm_deglitch #(
  parameter int unsigned HOLD_CYCLES = 250000
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  clkpm_vbus_if.deglitch vbus
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

  // Refuse a hold time the counter cannot serve
  if (HOLD_CYCLES < 1) begin : g_bad_hold
    $error("HOLD_CYCLES must be at least one");
  end

  logic level;
  logic next_level;
  logic [CW-1:0] timer;
  logic [CW-1:0] next_timer;

  // A change passes at once, then further changes wait for the timer
  always_comb begin
    next_level = level;
    next_timer = timer;
    if (timer != '0) begin
      next_timer = timer - 1'b1;
    end else if (vbus.raw != level) begin
      next_level = vbus.raw;
      next_timer = CW'(HOLD_CYCLES);
    end
  end

  // Runs on the crystal clock so it works while unpowered
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      level <= 1'b0;
      timer <= '0;
    end else begin
      level <= next_level;
      timer <= next_timer;
    end
  end

  assign vbus.stable = level;

endmodule : clkpm_deglitch

`default_nettype wire

/* logic/clkpm_map.svh */
// Register offsets, field positions, reset values and timing constants
`ifndef CLKPM_MAP_SVH
`define CLKPM_MAP_SVH

// Register byte addresses
`define CLKPM_PIXEL_PLL_CTRL_ADDR 16'h7000
`define CLKPM_SYSTEM_PLL_CTRL_ADDR 16'h700C
`define CLKPM_POWER_CTRL_ADDR 16'h7020
`define CLKPM_POWER_STATUS_ADDR 16'h7024

// PLL control register fields
`define CLKPM_PLL_GATE_BIT 31
`define CLKPM_PLL_LOCK_LSB 4
`define CLKPM_PLL_BYPASS_LSB 2
`define CLKPM_PLL_RESET_LSB 0

// Power control register fields
`define CLKPM_KEEP_XTAL_BIT 0
`define CLKPM_SELF_POWERED_BIT 1
`define CLKPM_VIDEO_EN_LSB 4

// Power status register fields
`define CLKPM_STATE_LSB 0
`define CLKPM_VBUS_OK_BIT 3

// Reset values of the PLL controls: gate set, stages in reset and bypass
`define CLKPM_PLL_GATE_RESET 1'h1
`define CLKPM_PLL_STAGE_RESET 2'h3

// Timing
`define CLKPM_CLK_HZ 25000000
`define CLKPM_DEGLITCH_US 10000

`endif

/* logic/clkpm_pkg.sv */
// Types shared by the clock and power manager
`default_nettype none

package clkpm_pkg;

  // Device power states
  typedef enum logic [2:0] {
    PS_RESET,
    PS_UNPOWERED,
    PS_UNCONFIGURED,
    PS_CONFIGURED,
    PS_SUSPEND
  } clkpm_state_e;

  // Software controls of one PLL
  typedef struct packed {
    logic gate;
    logic [1:0] bypass;
    logic [1:0] stage_reset;
  } clkpm_pll_ctrl_s;

endpackage : clkpm_pkg

`default_nettype wire

/* logic/clkpm_top.sv */
// Clock and power manager: power states, block enables, PLL control
`timescale 1ns/1ps
`default_nettype none
`include "clkpm_map.svh"

// How it works
// - Reset pin holds the reset state
// - Self-powered without bus voltage means unpowered
// - Suspend exits only on resume, reset or bus-voltage loss when self-powered
// - Deglitcher blocks changes for 10 ms
// - Deglitcher on crystal clock, enables oscillator
// - PHY and core on outside reset/unpowered
// - Oscillator on when unconfigured or configured
// - Keep-alive bit keeps oscillator always on
// - Function blocks enabled only when configured
// - Video output needs enable and connection
// - Memory clock PLL/2, core clock PLL/4
// - Pixel clock is pixel PLL halved
// - PLL stages reset and bypassed after reset
// - Setting gate stops derived clocks cleanly
// - Clearing gate restarts derived clocks cleanly when configured
// - PLL gate bits reset to one
// - Lock indicators synchronised before reading
module clkpm_top #(
  parameter int unsigned DEGLITCH_CYCLES =
    (`CLKPM_CLK_HZ / 1000000) * `CLKPM_DEGLITCH_US
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_bus_voltage_detect,
  input wire logic i_usb_configured,
  input wire logic i_usb_reset,
  input wire logic i_usb_suspend,
  input wire logic i_usb_resume,
  input wire logic [2:0] i_video_connected,
  input wire logic [1:0] i_sys_pll_stage_locked,
  input wire logic [1:0] i_pix_pll_stage_locked,
  input wire logic i_sys_pll_clk,
  input wire logic i_pix_pll_clk,
  output logic o_xtal_en,
  output logic o_phy_en,
  output logic o_usb_device_core_en,
  output logic o_func_en,
  output logic [2:0] o_video_en,
  output logic [1:0] o_sys_pll_stage_reset,
  output logic [1:0] o_sys_pll_stage_bypass,
  output logic [1:0] o_pix_pll_stage_reset,
  output logic [1:0] o_pix_pll_stage_bypass,
  output logic o_memory_clock,
  output logic o_core_clock,
  output logic o_pixel_clock,
  output logic [2:0] o_power_state
);

  // Refuse a deglitch span the timer cannot serve
  if (DEGLITCH_CYCLES < 1) begin : g_bad_deglitch
    $error("DEGLITCH_CYCLES must be at least one");
  end

  // Packs one PLL control register image for reading
  function automatic logic [31:0] pll_word(
    input clkpm_pkg::clkpm_pll_ctrl_s c,
    input logic [1:0] lock
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CLKPM_PLL_GATE_BIT] = c.gate;
    w[`CLKPM_PLL_LOCK_LSB +: 2] = lock;
    w[`CLKPM_PLL_BYPASS_LSB +: 2] = c.bypass;
    w[`CLKPM_PLL_RESET_LSB +: 2] = c.stage_reset;
    return w;
  endfunction : pll_word

  // Takes the writable fields of a PLL control register
  function automatic clkpm_pkg::clkpm_pll_ctrl_s pll_load(
    input logic [31:0] w
  );
    clkpm_pkg::clkpm_pll_ctrl_s c;
    c.gate = w[`CLKPM_PLL_GATE_BIT];
    c.bypass = w[`CLKPM_PLL_BYPASS_LSB +: 2];
    c.stage_reset = w[`CLKPM_PLL_RESET_LSB +: 2];
    return c;
  endfunction : pll_load

  clkpm_vbus_if vbus ();

  clkpm_pkg::clkpm_state_e state;
  clkpm_pkg::clkpm_state_e next_state;
  logic was_configured;
  logic next_was_configured;

  clkpm_pkg::clkpm_pll_ctrl_s sys_pll;
  clkpm_pkg::clkpm_pll_ctrl_s next_sys_pll;
  clkpm_pkg::clkpm_pll_ctrl_s pix_pll;
  clkpm_pkg::clkpm_pll_ctrl_s next_pix_pll;
  logic keep_xtal;
  logic next_keep_xtal;
  logic self_powered;
  logic next_self_powered;
  logic [2:0] video_enable;
  logic [2:0] next_video_enable;
  logic [31:0] next_rdata;

  logic [1:0] sys_lock_meta;
  logic [1:0] sys_lock_sync;
  logic [1:0] pix_lock_meta;
  logic [1:0] pix_lock_sync;

  logic configured;
  logic next_xtal_en;
  logic next_phy_en;
  logic next_func_en;
  logic [2:0] next_video_en;
  logic [1:0] next_sys_reset;
  logic [1:0] next_sys_bypass;
  logic [1:0] next_pix_reset;
  logic [1:0] next_pix_bypass;
  logic sys_gate;
  logic pix_gate;
  logic vbus_ok;

  assign vbus.raw = i_bus_voltage_detect;
  assign vbus_ok = vbus.stable;

  // Bus-voltage deglitcher in the crystal clock domain
  clkpm_deglitch #(
    .HOLD_CYCLES(DEGLITCH_CYCLES)
  ) u_deglitch (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .vbus(vbus.deglitch)
  );

  // Power state sequencing
  always_comb begin
    next_state = state;
    next_was_configured = was_configured;
    unique case (state)
      clkpm_pkg::PS_RESET: begin
        next_state = clkpm_pkg::PS_UNCONFIGURED;
      end
      clkpm_pkg::PS_UNPOWERED: begin
        if (vbus_ok) begin
          next_state = clkpm_pkg::PS_UNCONFIGURED;
        end
      end
      clkpm_pkg::PS_UNCONFIGURED: begin
        if (i_usb_suspend) begin
          next_state = clkpm_pkg::PS_SUSPEND;
          next_was_configured = 1'b0;
        end else if (i_usb_configured) begin
          next_state = clkpm_pkg::PS_CONFIGURED;
        end
      end
      clkpm_pkg::PS_CONFIGURED: begin
        if (i_usb_reset) begin
          next_state = clkpm_pkg::PS_UNCONFIGURED;
        end else if (i_usb_suspend) begin
          next_state = clkpm_pkg::PS_SUSPEND;
          next_was_configured = 1'b1;
        end
      end
      clkpm_pkg::PS_SUSPEND: begin
        // No wakeup source of our own: only resume, USB reset or the self-powered bus-voltage loss below leave
        if (i_usb_reset) begin
          next_state = clkpm_pkg::PS_UNCONFIGURED;
        end else if (i_usb_resume) begin
          next_state = was_configured ? clkpm_pkg::PS_CONFIGURED
                                      : clkpm_pkg::PS_UNCONFIGURED;
        end
      end
      default: begin
        next_state = clkpm_pkg::PS_RESET;
      end
    endcase
    // Outside the reset state, loss of bus voltage wins over every other move when self-powered
    if (state != clkpm_pkg::PS_RESET && self_powered && !vbus_ok) begin
      next_state = clkpm_pkg::PS_UNPOWERED;
    end
  end

  // Reset pin forces and holds the reset state
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= clkpm_pkg::PS_RESET;
      was_configured <= 1'b0;
    end else begin
      state <= next_state;
      was_configured <= next_was_configured;
    end
  end

  // Register writes
  always_comb begin
    next_sys_pll = sys_pll;
    next_pix_pll = pix_pll;
    next_keep_xtal = keep_xtal;
    next_self_powered = self_powered;
    next_video_enable = video_enable;
    if (i_wr) begin
      unique case (i_addr)
        `CLKPM_PIXEL_PLL_CTRL_ADDR: begin
          next_pix_pll = pll_load(i_wdata);
        end
        `CLKPM_SYSTEM_PLL_CTRL_ADDR: begin
          next_sys_pll = pll_load(i_wdata);
        end
        `CLKPM_POWER_CTRL_ADDR: begin
          next_keep_xtal = i_wdata[`CLKPM_KEEP_XTAL_BIT];
          next_self_powered = i_wdata[`CLKPM_SELF_POWERED_BIT];
          next_video_enable = i_wdata[`CLKPM_VIDEO_EN_LSB +: 3];
        end
        default: begin
        end
      endcase
    end
  end

  // Register reads, answered in the following cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (i_rd) begin
      unique case (i_addr)
        `CLKPM_PIXEL_PLL_CTRL_ADDR: begin
          next_rdata = pll_word(pix_pll, pix_lock_sync);
        end
        `CLKPM_SYSTEM_PLL_CTRL_ADDR: begin
          next_rdata = pll_word(sys_pll, sys_lock_sync);
        end
        `CLKPM_POWER_CTRL_ADDR: begin
          next_rdata[`CLKPM_KEEP_XTAL_BIT] = keep_xtal;
          next_rdata[`CLKPM_SELF_POWERED_BIT] = self_powered;
          next_rdata[`CLKPM_VIDEO_EN_LSB +: 3] = video_enable;
        end
        `CLKPM_POWER_STATUS_ADDR: begin
          next_rdata[`CLKPM_STATE_LSB +: 3] = state;
          next_rdata[`CLKPM_VBUS_OK_BIT] = vbus_ok;
        end
        default: begin
        end
      endcase
    end
  end

  // Control registers; PLLs start gated, reset and bypassed
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sys_pll.gate <= `CLKPM_PLL_GATE_RESET;
      sys_pll.bypass <= `CLKPM_PLL_STAGE_RESET;
      sys_pll.stage_reset <= `CLKPM_PLL_STAGE_RESET;
      pix_pll.gate <= `CLKPM_PLL_GATE_RESET;
      pix_pll.bypass <= `CLKPM_PLL_STAGE_RESET;
      pix_pll.stage_reset <= `CLKPM_PLL_STAGE_RESET;
      keep_xtal <= 1'b0;
      self_powered <= 1'b0;
      video_enable <= 3'h0;
      o_rdata <= 32'h0000_0000;
    end else begin
      sys_pll <= next_sys_pll;
      pix_pll <= next_pix_pll;
      keep_xtal <= next_keep_xtal;
      self_powered <= next_self_powered;
      video_enable <= next_video_enable;
      o_rdata <= next_rdata;
    end
  end

  // Lock indicators pass two flip-flops before software sees them
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sys_lock_meta <= 2'h0;
      sys_lock_sync <= 2'h0;
      pix_lock_meta <= 2'h0;
      pix_lock_sync <= 2'h0;
    end else begin
      sys_lock_meta <= i_sys_pll_stage_locked;
      sys_lock_sync <= sys_lock_meta;
      pix_lock_meta <= i_pix_pll_stage_locked;
      pix_lock_sync <= pix_lock_meta;
    end
  end

  // Block enables from the power state
  always_comb begin
    configured = (state == clkpm_pkg::PS_CONFIGURED);
    next_xtal_en = keep_xtal
      || state == clkpm_pkg::PS_UNCONFIGURED
      || configured
      || (state == clkpm_pkg::PS_UNPOWERED && vbus_ok);
    next_phy_en = state == clkpm_pkg::PS_UNCONFIGURED
      || configured
      || state == clkpm_pkg::PS_SUSPEND;
    next_func_en = configured;
    next_video_en = {3{configured}} & video_enable
      & i_video_connected;
    // PLLs stay reset and bypassed outside the configured state
    next_sys_reset = sys_pll.stage_reset | {2{!configured}};
    next_sys_bypass = sys_pll.bypass | {2{!configured}};
    next_pix_reset = pix_pll.stage_reset | {2{!configured}};
    next_pix_bypass = pix_pll.bypass | {2{!configured}};
  end

  // Registered enables
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_xtal_en <= 1'b0;
      o_phy_en <= 1'b0;
      o_usb_device_core_en <= 1'b0;
      o_func_en <= 1'b0;
      o_video_en <= 3'h0;
      o_sys_pll_stage_reset <= `CLKPM_PLL_STAGE_RESET;
      o_sys_pll_stage_bypass <= `CLKPM_PLL_STAGE_RESET;
      o_pix_pll_stage_reset <= `CLKPM_PLL_STAGE_RESET;
      o_pix_pll_stage_bypass <= `CLKPM_PLL_STAGE_RESET;
      o_power_state <= 3'h0;
      sys_gate <= 1'b1;
      pix_gate <= 1'b1;
    end else begin
      o_xtal_en <= next_xtal_en;
      o_phy_en <= next_phy_en;
      o_usb_device_core_en <= next_phy_en;
      o_func_en <= next_func_en;
      o_video_en <= next_video_en;
      o_sys_pll_stage_reset <= next_sys_reset;
      o_sys_pll_stage_bypass <= next_sys_bypass;
      o_pix_pll_stage_reset <= next_pix_reset;
      o_pix_pll_stage_bypass <= next_pix_bypass;
      o_power_state <= next_state;
      sys_gate <= next_sys_pll.gate || !next_func_en;
      pix_gate <= next_pix_pll.gate || !next_func_en;
    end
  end

  // Memory clock: system PLL divided by two
  clkpm_clkdiv #(
    .DIV(2)
  ) u_memory_div (
    .i_src_clk(i_sys_pll_clk),
    .i_rstn(i_rstn),
    .i_gate(sys_gate),
    .o_clk(o_memory_clock)
  );

  // Core clock: system PLL divided by four
  clkpm_clkdiv #(
    .DIV(4)
  ) u_core_div (
    .i_src_clk(i_sys_pll_clk),
    .i_rstn(i_rstn),
    .i_gate(sys_gate),
    .o_clk(o_core_clock)
  );

  // Pixel clock: pixel PLL halved
  clkpm_clkdiv #(
    .DIV(2)
  ) u_pixel_div (
    .i_src_clk(i_pix_pll_clk),
    .i_rstn(i_rstn),
    .i_gate(pix_gate),
    .o_clk(o_pixel_clock)
  );

endmodule : clkpm_top

`default_nettype wire

/* logic/clkpm_vbus_if.sv */
// Raw and deglitched bus-voltage detect between top and deglitcher
`timescale 1ns/1ps
`default_nettype none

interface clkpm_vbus_if;
  logic raw;
  logic stable;
  modport deglitch (input raw, output stable);
  modport ctrl (output raw, input stable);
endinterface : clkpm_vbus_if

`default_nettype wire
